// ==== hw/apbs_coef_mem.sv ====
// Two-bank coefficient store, 16-bit words written one byte at a time.
// Assumes a single clock; read data appear one cycle after the address.
`timescale 1ns/100ps
module apbs_coef_mem (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_wr,
  input  wire logic        i_wr_hi,
  input  wire logic [6:0]  i_wr_addr,
  input  wire logic [7:0]  i_wr_byte,
  input  wire logic [6:0]  i_rd_addr,
  output logic      [15:0] o_rd_data
);
  import apbs_pkg::*;

  logic [15:0] mem_reg [128];
  logic [15:0] mem_next [128];
  logic [15:0] rd_next;

  ////////////////////////////////////////////////////////////////////////
  // Byte write into the addressed word, registered read
  always_comb begin
    mem_next = mem_reg;
    if (i_wr) begin
      if (i_wr_hi)
        mem_next[i_wr_addr][15:8] = i_wr_byte;
      else
        mem_next[i_wr_addr][7:0] = i_wr_byte;
    end
    rd_next = mem_reg[i_rd_addr];
  end

  // Reset loads defaults into both banks: flat for the IIR and biquads, unity on every fifth FIR tap
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 128; i++)
        mem_reg[i] <= apbs_coef_default(6'(i));
      o_rd_data <= 16'h0000;
    end else begin
      mem_reg   <= mem_next;
      o_rd_data <= rd_next;
    end
  end

endmodule

// ==== hw/apbs_top.sv ====
// Decimation and processing-chain engine behind a stereo delta-sigma ADC.
// Assumes modulator bits arrive on i_clock with a valid strobe, and that
// the downstream serial port accepts samples with a valid/ready handshake.
`timescale 1ns/100ps
// Summary of operation
// - Each enabled channel's modulator bits are decimated to Nyquist-rate samples.
// - Decimation type A, B or C follows the selected chain.
// - Chains add first-order IIR, biquads or FIR after decimation.
// - All IIR, biquad and FIR coefficients are software-writable.
// - Writing the chain-select register picks the active chain.
// - Chain 1 runs after reset until software selects another.
// - Chains 1-6: filter A, ratio 128 or 64, five biquads or 25 taps.
// - Chains 7-12: filter B, ratio 64, three biquads or 20 taps.
// - Chains 13-18: filter C, ratio 32, five biquads or 25 taps.
// - Every chain runs the IIR; its resource class is reported.
// - Coefficients are 16-bit two's complement in two consecutive byte registers.
// - In adaptive mode the coefficient banks swap without stopping samples.
module apbs_top (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_mod_valid,
  input  wire logic        i_mod_left,
  input  wire logic        i_mod_right,
  input  wire logic [7:0]  i_adc_oversampling_ratio,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_page,
  input  wire logic [6:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_sample_valid,
  input  wire logic        i_sample_ready,
  output logic      [15:0] o_sample_left,
  output logic      [15:0] o_sample_right,
  output logic             o_left_active,
  output logic      [3:0]  o_resource_class,
  output logic             o_active_bank
);
  import apbs_pkg::*;

  // Registers and their next values
  logic [7:0]         sel_reg, sel_next, rdata_next;
  logic               adapt_reg, adapt_next, swp_reg, swp_next, bank_reg, bank_next;
  logic [7:0]         win_reg, win_next, ones_l_reg, ones_l_next, ones_r_reg, ones_r_next;
  logic signed [15:0] dec_l_reg, dec_l_next, dec_r_reg, dec_r_next;
  logic               pend_reg, pend_next;
  apbs_state_t        st_reg, st_next;
  apbs_chain_t        cfg_reg, cfg_next, cfg_sel;
  logic               ch_reg, ch_next, dbl_reg, dbl_next, macv_reg, macv_next;
  logic [2:0]         stg_reg, stg_next;
  logic [4:0]         step_reg, step_next, nsteps;
  logic signed [39:0] acc_reg, acc_next, acc_sum;
  logic signed [15:0] x_reg, x_next, opnd_reg, opnd_next, opnd, y, out_r_reg, out_r_next;
  logic signed [15:0] ix1_reg [2], ix1_next [2], iy1_reg [2], iy1_next [2];
  logic signed [15:0] bx1_reg [2][APBS_NBQ_MAX], bx1_next [2][APBS_NBQ_MAX];
  logic signed [15:0] bx2_reg [2][APBS_NBQ_MAX], bx2_next [2][APBS_NBQ_MAX];
  logic signed [15:0] by1_reg [2][APBS_NBQ_MAX], by1_next [2][APBS_NBQ_MAX];
  logic signed [15:0] by2_reg [2][APBS_NBQ_MAX], by2_next [2][APBS_NBQ_MAX];
  logic signed [15:0] fh_reg [2][APBS_FIR_MAX], fh_next [2][APBS_FIR_MAX];
  logic [31:0]        fd_reg [2], fd_next [2];
  logic               wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0]         cnt_reg, cnt_next;
  logic [5:0]         cidx;
  logic [15:0]        coef;
  logic [7:0]         osr;
  logic [3:0]         sh;
  logic               coef_wr, last_bit, push, pop;
  logic [2:0]         bq;

  ////////////////////////////////////////////////////////////////////////
  // Coefficient store: in adaptive mode software fills the bank the engine is not using, otherwise the active bank
  assign coef_wr = i_reg_wr && i_reg_page == APBS_PAGE_COEF &&
                   i_reg_addr >= APBS_REG_COEF_FIRST;
  apbs_coef_mem u_coef_mem (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_wr      (coef_wr),
    .i_wr_hi   (~i_reg_addr[0]),
    .i_wr_addr ({bank_reg ^ adapt_reg, i_reg_addr[6:1]}),
    .i_wr_byte (i_reg_wdata),
    .i_rd_addr ({bank_reg, cidx}),
    .o_rd_data (coef)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register file: chain select, bank control, read-back
  always_comb begin
    sel_next   = sel_reg;
    adapt_next = adapt_reg;
    swp_next   = swp_reg;
    bank_next  = bank_reg;
    rdata_next = o_reg_rdata;
    // Swap only between samples so no sample mixes two banks
    if (swp_reg && st_reg == APBS_ST_IDLE) begin
      bank_next = ~bank_reg;
      swp_next  = 1'b0;
    end
    if (i_reg_wr && i_reg_page == APBS_PAGE_CTRL && i_reg_addr == APBS_REG_CHAIN_SEL)
      sel_next = i_reg_wdata;
    if (i_reg_wr && i_reg_page == APBS_PAGE_COEF && i_reg_addr == APBS_REG_BANK_CTRL) begin
      adapt_next = i_reg_wdata[APBS_BIT_ADAPT];
      if (i_reg_wdata[APBS_BIT_SWITCH] && adapt_reg)
        swp_next = 1'b1;
    end
    if (i_reg_rd) begin
      if (i_reg_page == APBS_PAGE_CTRL && i_reg_addr == APBS_REG_CHAIN_SEL)
        rdata_next = sel_reg;
      else if (i_reg_page == APBS_PAGE_COEF && i_reg_addr == APBS_REG_BANK_CTRL)
        rdata_next = {5'h00, bank_reg, swp_reg, adapt_reg};
      else
        rdata_next = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decimator: count ones over one oversampling window per channel
  assign cfg_sel = apbs_chain_decode(sel_reg);
  always_comb begin
    case (cfg_sel.filt)
      APBS_FILT_A: osr = (i_adc_oversampling_ratio == APBS_OSR_64) ? APBS_OSR_64
                                                                   : APBS_OSR_128;
      APBS_FILT_B: osr = APBS_OSR_64;
      default:     osr = APBS_OSR_32;
    endcase
    case (osr)
      APBS_OSR_128: sh = APBS_SH_128;
      APBS_OSR_64:  sh = APBS_SH_64;
      default:      sh = APBS_SH_32;
    endcase
    last_bit    = i_mod_valid && (win_reg >= osr - 8'h01);
    win_next    = win_reg;
    ones_l_next = ones_l_reg;
    ones_r_next = ones_r_reg;
    dec_l_next  = dec_l_reg;
    dec_r_next  = dec_r_reg;
    pend_next   = pend_reg && st_reg != APBS_ST_IDLE;
    if (i_mod_valid) begin
      win_next    = last_bit ? 8'h00 : win_reg + 8'h01;
      ones_l_next = last_bit ? 8'h00 : ones_l_reg + {7'h00, i_mod_left && cfg_sel.stereo};
      ones_r_next = last_bit ? 8'h00 : ones_r_reg + {7'h00, i_mod_right};
    end
    // Signed density of ones, scaled to full 16-bit range
    if (last_bit) begin
      dec_r_next = apbs_sat16((40'($signed({1'b0, ones_r_reg + {7'h00, i_mod_right}, 1'b0}))
                   - 40'($signed({2'b00, osr}))) <<< sh);
      dec_l_next = cfg_sel.stereo ?
                   apbs_sat16((40'($signed({1'b0, ones_l_reg + {7'h00, i_mod_left}, 1'b0}))
                   - 40'($signed({2'b00, osr}))) <<< sh) : 16'sh0000;
      pend_next  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand and coefficient index for the current step
  always_comb begin
    bq   = stg_reg - 3'h1;
    opnd = x_reg;
    dbl_next = 1'b0;
    if (stg_reg == APBS_STG_IIR) begin
      nsteps = APBS_IIR_STEPS;
      cidx   = APBS_CIDX_IIR + 6'(step_reg);
      if (step_reg == 5'h01) opnd = ix1_reg[ch_reg];
      if (step_reg == 5'h02) opnd = iy1_reg[ch_reg];
    end else if (stg_reg == APBS_STG_FIR) begin
      nsteps = cfg_reg.taps;
      cidx   = APBS_CIDX_FIR + 6'(step_reg);
      if (step_reg != 5'h00) opnd = fh_reg[ch_reg][step_reg - 5'h01];
    end else begin
      nsteps = APBS_BQ_STEPS;
      cidx   = APBS_CIDX_BQ + 6'(bq) * APBS_CIDX_BQ_LEN + 6'(step_reg);
      dbl_next = step_reg == 5'h01 || step_reg == 5'h03;                   // Doubled N1, D1
      case (step_reg)
        5'h01:   opnd = bx1_reg[ch_reg][bq];
        5'h02:   opnd = bx2_reg[ch_reg][bq];
        5'h03:   opnd = by1_reg[ch_reg][bq];
        5'h04:   opnd = by2_reg[ch_reg][bq];
        default: opnd = x_reg;
      endcase
    end
    if (!ch_reg)
      cidx = cidx + APBS_CIDX_RIGHT;
    acc_sum = acc_reg + (macv_reg ? ((40'(signed'(coef)) * 40'(opnd_reg)) <<< dbl_reg)
                                  : 40'sh0);
    y = apbs_sat16(acc_sum >>> APBS_Q_SHIFT);
  end

  ////////////////////////////////////////////////////////////////////////
  // Engine: right channel then left, IIR then biquads or FIR
  always_comb begin
    st_next = st_reg;  cfg_next = cfg_reg;  ch_next = ch_reg;  stg_next = stg_reg;
    step_next = step_reg;  acc_next = acc_reg;  x_next = x_reg;  opnd_next = opnd_reg;
    macv_next = 1'b0;  out_r_next = out_r_reg;
    ix1_next = ix1_reg;  iy1_next = iy1_reg;  fh_next = fh_reg;
    bx1_next = bx1_reg;  bx2_next = bx2_reg;  by1_next = by1_reg;  by2_next = by2_reg;
    push = 1'b0;
    case (st_reg)
      APBS_ST_IDLE: begin
        if (pend_reg) begin
          cfg_next = cfg_sel;
          ch_next  = 1'b0;
          stg_next = APBS_STG_IIR;
          step_next = 5'h00;
          acc_next = 40'sh0;
          x_next   = dec_r_reg;
          st_next  = APBS_ST_MAC;
        end
      end
      APBS_ST_MAC: begin
        acc_next  = acc_sum;
        opnd_next = opnd;
        macv_next = 1'b1;
        step_next = step_reg + 5'h01;
        if (step_reg == nsteps - 5'h01)
          st_next = APBS_ST_FIN;
      end
      APBS_ST_FIN: begin
        acc_next  = 40'sh0;
        step_next = 5'h00;
        x_next    = y;
        st_next   = APBS_ST_MAC;
        if (stg_reg == APBS_STG_IIR) begin
          ix1_next[ch_reg] = x_reg;
          iy1_next[ch_reg] = y;
        end else if (stg_reg == APBS_STG_FIR) begin
          fh_next[ch_reg][0] = x_reg;
          for (int i = 1; i < APBS_FIR_MAX; i++)
            fh_next[ch_reg][i] = fh_reg[ch_reg][i-1];
        end else begin
          bx2_next[ch_reg][bq] = bx1_reg[ch_reg][bq];
          bx1_next[ch_reg][bq] = x_reg;
          by2_next[ch_reg][bq] = by1_reg[ch_reg][bq];
          by1_next[ch_reg][bq] = y;
        end
        if (stg_reg == APBS_STG_IIR && cfg_reg.nbq != 3'h0)
          stg_next = 3'h1;
        else if (stg_reg == APBS_STG_IIR && cfg_reg.taps != 5'h00)
          stg_next = APBS_STG_FIR;
        else if (stg_reg != APBS_STG_IIR && stg_reg != APBS_STG_FIR && bq + 3'h1 < cfg_reg.nbq)
          stg_next = stg_reg + 3'h1;
        else if (!ch_reg && cfg_reg.stereo) begin
          out_r_next = y;
          ch_next  = 1'b1;
          stg_next = APBS_STG_IIR;
          x_next   = dec_l_reg;
        end else begin
          if (!ch_reg)
            out_r_next = y;
          else
            x_next = y;
          st_next = APBS_ST_PUSH;
        end
      end
      APBS_ST_PUSH: begin
        push = cnt_reg != 2'h2;                                            // Stall when full
        if (push)
          st_next = APBS_ST_IDLE;
      end
      default: st_next = APBS_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer
  assign pop = o_sample_valid && i_sample_ready;
  always_comb begin
    fd_next  = fd_reg;
    wp_next  = wp_reg ^ push;
    rp_next  = rp_reg ^ pop;
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    if (push)
      fd_next[wp_reg] = {(ch_reg ? x_reg : 16'sh0000), out_r_reg};
  end
  assign o_sample_valid   = cnt_reg != 2'h0;
  assign o_sample_left    = fd_reg[rp_reg][31:16];
  assign o_sample_right   = fd_reg[rp_reg][15:0];
  assign o_left_active    = cfg_reg.stereo;
  assign o_resource_class = cfg_reg.rclass;
  assign o_active_bank    = bank_reg;

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_reg <= APBS_CHAIN_RESET;
      cfg_reg <= apbs_chain_decode(APBS_CHAIN_RESET);
      o_reg_rdata <= 8'h00;  adapt_reg <= 1'b0;  swp_reg <= 1'b0;  bank_reg <= 1'b0;
      win_reg <= 8'h00;  ones_l_reg <= 8'h00;  ones_r_reg <= 8'h00;
      dec_l_reg <= 16'sh0000;  dec_r_reg <= 16'sh0000;  pend_reg <= 1'b0;
      st_reg <= APBS_ST_IDLE;  ch_reg <= 1'b0;  stg_reg <= APBS_STG_IIR;
      step_reg <= 5'h00;  acc_reg <= 40'sh0;  x_reg <= 16'sh0000;  opnd_reg <= 16'sh0000;
      dbl_reg <= 1'b0;  macv_reg <= 1'b0;  out_r_reg <= 16'sh0000;
      wp_reg <= 1'b0;  rp_reg <= 1'b0;  cnt_reg <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        ix1_reg[c] <= 16'sh0000;  iy1_reg[c] <= 16'sh0000;  fd_reg[c] <= 32'h00000000;
        for (int i = 0; i < APBS_NBQ_MAX; i++) begin
          bx1_reg[c][i] <= 16'sh0000;  bx2_reg[c][i] <= 16'sh0000;
          by1_reg[c][i] <= 16'sh0000;  by2_reg[c][i] <= 16'sh0000;
        end
        for (int i = 0; i < APBS_FIR_MAX; i++)
          fh_reg[c][i] <= 16'sh0000;
      end
    end else begin
      sel_reg <= sel_next;  cfg_reg <= cfg_next;  o_reg_rdata <= rdata_next;
      adapt_reg <= adapt_next;  swp_reg <= swp_next;  bank_reg <= bank_next;
      win_reg <= win_next;  ones_l_reg <= ones_l_next;  ones_r_reg <= ones_r_next;
      dec_l_reg <= dec_l_next;  dec_r_reg <= dec_r_next;  pend_reg <= pend_next;
      st_reg <= st_next;  ch_reg <= ch_next;  stg_reg <= stg_next;  step_reg <= step_next;
      acc_reg <= acc_next;  x_reg <= x_next;  opnd_reg <= opnd_next;
      dbl_reg <= dbl_next;  macv_reg <= macv_next;  out_r_reg <= out_r_next;
      wp_reg <= wp_next;  rp_reg <= rp_next;  cnt_reg <= cnt_next;  fd_reg <= fd_next;
      ix1_reg <= ix1_next;  iy1_reg <= iy1_next;  fh_reg <= fh_next;
      bx1_reg <= bx1_next;  bx2_reg <= bx2_next;  by1_reg <= by1_next;  by2_reg <= by2_next;
    end
  end

endmodule

// ==== pkg/apbs_pkg.sv ====
// Constants, types and decode helpers for the ADC processing block select.
// Assumes one clock shared by the modulator bit stream and the processing.
package apbs_pkg;

  // Register pages and offsets
  localparam logic [7:0] APBS_PAGE_CTRL      = 8'h00;
  localparam logic [7:0] APBS_PAGE_COEF      = 8'h04;
  localparam logic [6:0] APBS_REG_CHAIN_SEL  = 7'h3d;
  localparam logic [6:0] APBS_REG_BANK_CTRL  = 7'h01;
  localparam logic [6:0] APBS_REG_COEF_FIRST = 7'h02;
  localparam logic [7:0] APBS_CHAIN_RESET    = 8'h01;
  localparam logic [7:0] APBS_CHAIN_LAST     = 8'h12;

  // Bank control fields
  localparam int APBS_BIT_ADAPT  = 0;
  localparam int APBS_BIT_SWITCH = 1;
  localparam int APBS_BIT_ACTIVE = 2;

  // Coefficient space: index of the first coefficient of each stage
  localparam logic [5:0] APBS_CIDX_IIR    = 6'h04;
  localparam logic [5:0] APBS_CIDX_BQ     = 6'h07;
  localparam logic [5:0] APBS_CIDX_FIR    = 6'h07;
  localparam logic [5:0] APBS_CIDX_BQ_LEN = 6'h05;
  localparam logic [5:0] APBS_CIDX_RIGHT  = 6'h20;
  localparam logic [5:0] APBS_CIDX_BQ_END = 6'h1b;
  localparam logic [4:0] APBS_CIDX_CH_MSK = 5'h1f;
  localparam logic [15:0] APBS_COEF_UNITY = 16'h7fff;

  // Stage counts and stage codes
  localparam logic [4:0] APBS_IIR_STEPS = 5'h03;
  localparam logic [4:0] APBS_BQ_STEPS  = 5'h05;
  localparam logic [2:0] APBS_STG_IIR   = 3'h0;
  localparam logic [2:0] APBS_STG_FIR   = 3'h6;
  localparam int         APBS_FIR_MAX   = 25;
  localparam int         APBS_NBQ_MAX   = 5;
  localparam int         APBS_Q_SHIFT   = 15;

  // Oversampling ratios and scale shifts
  localparam logic [7:0] APBS_OSR_128 = 8'h80;
  localparam logic [7:0] APBS_OSR_64  = 8'h40;
  localparam logic [7:0] APBS_OSR_32  = 8'h20;
  localparam logic [3:0] APBS_SH_128  = 4'h8;
  localparam logic [3:0] APBS_SH_64   = 4'h9;
  localparam logic [3:0] APBS_SH_32   = 4'ha;

  typedef enum logic [1:0] {
    APBS_FILT_A = 2'h0,
    APBS_FILT_B = 2'h1,
    APBS_FILT_C = 2'h2
  } apbs_filt_t;

  typedef struct packed {
    apbs_filt_t  filt;
    logic        stereo;
    logic [2:0]  nbq;
    logic [4:0]  taps;
    logic [3:0]  rclass;
  } apbs_chain_t;

  typedef enum logic [3:0] {
    APBS_ST_IDLE = 4'h1,
    APBS_ST_MAC  = 4'h2,
    APBS_ST_FIN  = 4'h4,
    APBS_ST_PUSH = 4'h8
  } apbs_state_t;

  // Chain number to its fixed configuration; unknown numbers act as chain 1
  function automatic apbs_chain_t apbs_chain_decode(input logic [7:0] sel);
    case (sel)
      8'h02:   return '{APBS_FILT_A, 1'b1, 3'h5, 5'h00, 4'h8};
      8'h03:   return '{APBS_FILT_A, 1'b1, 3'h0, 5'h19, 4'h8};
      8'h04:   return '{APBS_FILT_A, 1'b0, 3'h0, 5'h00, 4'h3};
      8'h05:   return '{APBS_FILT_A, 1'b0, 3'h5, 5'h00, 4'h4};
      8'h06:   return '{APBS_FILT_A, 1'b0, 3'h0, 5'h19, 4'h4};
      8'h07:   return '{APBS_FILT_B, 1'b1, 3'h0, 5'h00, 4'h3};
      8'h08:   return '{APBS_FILT_B, 1'b1, 3'h3, 5'h00, 4'h4};
      8'h09:   return '{APBS_FILT_B, 1'b1, 3'h0, 5'h14, 4'h4};
      8'h0a:   return '{APBS_FILT_B, 1'b0, 3'h0, 5'h00, 4'h2};
      8'h0b:   return '{APBS_FILT_B, 1'b0, 3'h3, 5'h00, 4'h2};
      8'h0c:   return '{APBS_FILT_B, 1'b0, 3'h0, 5'h14, 4'h2};
      8'h0d:   return '{APBS_FILT_C, 1'b0, 3'h0, 5'h00, 4'h3};
      8'h0e:   return '{APBS_FILT_C, 1'b1, 3'h5, 5'h00, 4'h4};
      8'h0f:   return '{APBS_FILT_C, 1'b1, 3'h0, 5'h19, 4'h4};
      8'h10:   return '{APBS_FILT_C, 1'b0, 3'h0, 5'h00, 4'h2};
      8'h11:   return '{APBS_FILT_C, 1'b0, 3'h5, 5'h00, 4'h2};
      8'h12:   return '{APBS_FILT_C, 1'b0, 3'h0, 5'h19, 4'h2};
      default: return '{APBS_FILT_A, 1'b1, 3'h0, 5'h00, 4'h6};
    endcase
  endfunction

  // Reset coefficient: unity N0 for the IIR and each biquad, zero elsewhere
  function automatic logic [15:0] apbs_coef_default(input logic [5:0] idx);
    logic [5:0] off;
    off = {1'b0, idx[4:0] & APBS_CIDX_CH_MSK} - APBS_CIDX_BQ;
    if ({1'b0, idx[4:0]} == APBS_CIDX_IIR)
      return APBS_COEF_UNITY;
    if ({1'b0, idx[4:0]} >= APBS_CIDX_BQ && {1'b0, idx[4:0]} <= APBS_CIDX_BQ_END &&
        (off % APBS_CIDX_BQ_LEN) == 6'h00)
      return APBS_COEF_UNITY;
    return 16'h0000;
  endfunction

  // Saturate a wide signed value to 16 bits
  function automatic logic signed [15:0] apbs_sat16(input logic signed [39:0] v);
    if (v > 40'sh0000007fff)
      return 16'sh7fff;
    if (v < -40'sh0000008000)
      return -16'sh8000;
    return v[15:0];
  endfunction

endpackage

// ==== test/apbs_chk.sv ====
// Checker for the chain select block, bound onto apbs_top.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module apbs_chk
  import apbs_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_page,
  input wire logic [6:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        o_sample_valid,
  input wire logic        i_sample_ready,
  input wire logic [15:0] o_sample_left,
  input wire logic [15:0] o_sample_right,
  input wire logic        o_left_active,
  input wire logic [3:0]  o_resource_class
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Access to the chain-select register
  wire logic sel = (i_reg_page == APBS_PAGE_CTRL) && (i_reg_addr == APBS_REG_CHAIN_SEL);
  ////////////////////////////////////////////////////////////////////////////
  a_unmapped_zero: assert property (i_reg_rd && i_reg_page == APBS_PAGE_CTRL && !sel
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
  a_sel_readback: assert property (i_reg_wr && sel ##1 i_reg_rd && sel && !i_reg_wr
    |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("chain select readback wrong");
  a_buf_hold: assert property (o_sample_valid && !i_sample_ready
    |=> o_sample_valid && $stable(o_sample_left) && $stable(o_sample_right))
    else $error("stalled sample lost or changed");
  a_class_set: assert property (o_resource_class inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h8})
    else $error("resource class outside table");
  a_stereo_class: assert property (o_left_active |-> o_resource_class inside {4'h3, 4'h4, 4'h6, 4'h8})
    else $error("stereo chain class wrong");
  a_right_class: assert property (!o_left_active |-> o_resource_class inside {4'h2, 4'h3, 4'h4})
    else $error("right-only chain class wrong");
  a_reset_out: assert property ($rose(i_rst_n) |-> o_left_active && o_resource_class == 4'h6
    && !o_sample_valid) else $error("reset outputs wrong");
  c_stall: cover property (o_sample_valid && !i_sample_ready);
  c_right: cover property (!o_left_active && o_sample_valid);
  c_class8: cover property (o_resource_class == 4'h8);
endmodule
bind apbs_top apbs_chk i_chk (.i_clock, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_page,
  .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_sample_valid, .i_sample_ready,
  .o_sample_left, .o_sample_right, .o_left_active, .o_resource_class);

// ==== test/apbs_mod_src.sv ====
// Modulator model: one bit pair per cycle, left full-scale high, right low.
// Assumes the block samples on the rising edge; bits change on the falling one.
`timescale 1ns/100ps
module apbs_mod_src (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  output logic      o_mod_valid,
  output logic      o_mod_left,
  output logic      o_mod_right
);
  // Stream starts after reset and runs without gaps
  initial begin
    o_mod_valid = 1'b0;
    forever @(negedge i_clock) o_mod_valid <= i_rst_n;
  end
  assign o_mod_left  = o_mod_valid;
  assign o_mod_right = 1'b0;
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the chain select block.
// Assumes apbs_top, the modulator model and the checker bind are compiled.
`timescale 1ns/100ps
module tb_top;
  import apbs_pkg::*;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
  logic        clk, rst_n, mv, ml, mr, reg_wr, reg_rd, sv, ready, la, bank;
  logic [7:0]  osr, page, wdata, rdata;
  logic [6:0]  addr;
  logic [15:0] sl, sr;
  logic [3:0]  cls;
  int          n_errors, checks_done, cycles;
  localparam logic [3:0] CLS [18] = '{4'h6, 4'h8, 4'h8, 4'h3, 4'h4, 4'h4, 4'h3, 4'h4, 4'h4,
    4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h2, 4'h2, 4'h2};
  localparam bit STEREO [18] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  apbs_mod_src i_src (.i_clock(clk), .i_rst_n(rst_n), .o_mod_valid(mv), .o_mod_left(ml),
    .o_mod_right(mr));
  apbs_top i_dut (.i_clock(clk), .i_rst_n(rst_n), .i_mod_valid(mv), .i_mod_left(ml),
    .i_mod_right(mr), .i_adc_oversampling_ratio(osr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_page(page), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_sample_valid(sv), .i_sample_ready(ready), .o_sample_left(sl), .o_sample_right(sr),
    .o_left_active(la), .o_resource_class(cls), .o_active_bank(bank));
  ////////////////////////////////////////////////////////////////////////////
  // Register write: strobe for one rising edge
  task automatic wr(input logic [7:0] p, input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    page = p;
    addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // Register read: data taken one and a half cycles after the read edge
  task automatic rd(input logic [7:0] p, input logic [6:0] a, output logic [7:0] q);
    page = p;
    addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    q = rdata;
  endtask
  task automatic t_reset;
    logic [7:0] q;
    `CHK("valid", 1'b0, sv)
    `CHK("left_active", 1'b1, la)
    `CHK("class", 4'h6, cls)
    rd(APBS_PAGE_CTRL, APBS_REG_CHAIN_SEL, q);
    `CHK("chain_sel", APBS_CHAIN_RESET, q)
  endtask
  task automatic t_regs;
    logic [7:0] q;
    wr(APBS_PAGE_CTRL, APBS_REG_CHAIN_SEL, 8'h0d);
    rd(APBS_PAGE_CTRL, APBS_REG_CHAIN_SEL, q);
    `CHK("chain_sel", 8'h0d, q)
    rd(APBS_PAGE_CTRL, 7'h10, q);
    `CHK("unmapped", 8'h00, q)
    wr(APBS_PAGE_COEF, APBS_REG_BANK_CTRL, 8'h01);
    wr(APBS_PAGE_COEF, APBS_REG_BANK_CTRL, 8'h03);
    repeat (50) @(negedge clk);
    rd(APBS_PAGE_COEF, APBS_REG_BANK_CTRL, q);
    `CHK("bank_ctrl", 8'h05, q)
    `CHK("active_bank", 1'b1, bank)
    wr(APBS_PAGE_COEF, 7'h3e, 8'h00);
    wr(APBS_PAGE_COEF, 7'h3f, 8'h01);
    rd(APBS_PAGE_COEF, 7'h3f, q);
    `CHK("coef_wo", 8'h00, q)
  endtask
  // Every chain: select, run, stall the consumer, inspect the held entry
  task automatic t_chains;
    logic [15:0] v;
    // Fill every FIR tap of both channels in the idle bank, then swap it in
    for (int j = 7; j < 64; j++) begin
      if (j % 32 >= 7) begin
        v = ((j % 32 - 7) % 5 == 0) ? APBS_COEF_UNITY : 16'h0000;
        wr(APBS_PAGE_COEF, 7'(2 * j), v[15:8]);
        wr(APBS_PAGE_COEF, 7'(2 * j + 1), v[7:0]);
      end
    end
    wr(APBS_PAGE_COEF, APBS_REG_BANK_CTRL, 8'h03);
    for (int c = 1; c <= 18; c++) begin
      osr = (c > 12) ? APBS_OSR_32 : (c > 6 || !c[0]) ? APBS_OSR_64 : APBS_OSR_128;
      wr(APBS_PAGE_CTRL, APBS_REG_CHAIN_SEL, 8'(c));
      repeat (400) @(negedge clk);
      ready = 1'b0;
      repeat (400) @(negedge clk);
      `CHK("class", CLS[c-1], cls)
      `CHK("left_active", STEREO[c-1], la)
      `CHK("valid", 1'b1, sv)
      `CHK("active_bank", 1'b0, bank)
      if (!STEREO[c-1]) `CHK("left", 16'h0000, sl)
      if (STEREO[c-1]) `CHK("left_sign", 2'b01, sl[15:14])
      `CHK("right_sign", 2'b10, sr[15:14])
      ready = 1'b1;
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report;
    end
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ready = 1'b1;
    osr = APBS_OSR_128;
    page = 8'h00;
    addr = 7'h00;
    wdata = 8'h00;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_chains;
    final_report;
  end
endmodule
